// ---- dsl_freq_detect.sv ----
// Frequency level detector, hysteresis below the level.
// Assumes 0.01 Hz frequencies and a band in 0.01 % of the level.
`timescale 1ns/1ps
module dsl_freq_detect
   import dsl_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Tick
   dsl_tick_if.dst tk,
   // Compare
   input wire logic [15:0] freq,
   input wire logic [15:0] level,
   input wire logic [15:0] band,
   // Result
   output logic reached
);
   logic reached_reg, reached_next;
   logic [31:0] hyst;
   logic [16:0] low_lvl;

   always_comb
   begin
      hyst = (32'(level) * 32'(band)) / 32'd10000;
      low_lvl = 17'(level) - 17'(hyst[15:0]);
      reached_next = reached_reg;
      if (freq >= level)
         reached_next = 1'b1;
      else if (low_lvl[16] || 17'(freq) < low_lvl)
         reached_next = 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         reached_reg <= 1'b0;
      else if (tk.ce)
         reached_reg <= reached_next;
   end

   assign reached = reached_reg;
endmodule // dsl_freq_detect

// ---- dsl_gp_timer.sv ----
// General timer: counts 0.1 s ticks while start holds.
// Assumes a one-cycle tick pulse.
`timescale 1ns/1ps
module dsl_gp_timer
   import dsl_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Tick
   dsl_tick_if.dst tk,
   // Control
   input wire logic start,
   input wire logic [15:0] preset,
   // Result
   output logic done
);
   logic [15:0] cnt_reg, cnt_next;
   logic done_reg, done_next;

   always_comb
   begin
      cnt_next = cnt_reg;
      done_next = done_reg;
      if (!start)
      begin
         cnt_next = 16'h0000;
         done_next = 1'b0;
      end
      else if (cnt_reg >= preset)
         done_next = 1'b1;
      else if (tk.tick)
         cnt_next = cnt_reg + 16'h0001;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_reg <= 16'h0000;
         done_reg <= 1'b0;
      end
      else if (tk.ce)
      begin
         cnt_reg <= cnt_next;
         done_reg <= done_next;
      end
   end

   assign done = done_reg;
endmodule // dsl_gp_timer

// ---- dsl_monitor.sv ----
// Port checker for the supervisor.
// Assumes default brake settings and ce high.
`timescale 1ns/1ps
module dsl_monitor
   import dsl_pkg::*;
(
   // Clock and reset
   input wire logic pclk, presetn, ce,
   // Observed signals
   input wire logic brake_on, speed_search, supply_ok, pl_ramp_down,
   input wire logic pl_extra_action, auto_restart, fault_alarm, run_cmd,
   input wire logic motor_overload_alarm, timer_one_start, timer_one_done,
   input wire logic [15:0] dc_bus_dv
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_brk_on; ce && dc_bus_dv > BRAKE_ON_400V |=> brake_on; endproperty
   a_brk_on: assert property (p_brk_on) else $error("brake late");
   property p_brk_hold; ce && brake_on &&
      dc_bus_dv > BRAKE_ON_400V - BRAKE_HYST_RST |=> brake_on; endproperty
   a_brk_hold: assert property (p_brk_hold) else $error("brake drop");
   property p_search; speed_search |-> supply_ok ##1 !speed_search; endproperty
   a_search: assert property (p_search) else $error("bad search");
   property p_ramp; pl_ramp_down |-> !supply_ok; endproperty
   a_ramp: assert property (p_ramp) else $error("bad ramp");
   property p_extra; pl_extra_action |-> pl_ramp_down; endproperty
   a_extra: assert property (p_extra) else $error("bad extra");
   property p_rst; auto_restart |-> !$past(fault_alarm) ##1 !auto_restart;
   endproperty
   a_rst: assert property (p_rst) else $error("bad restart");
   property p_ovl; ce && !run_cmd |=> !motor_overload_alarm; endproperty
   a_ovl: assert property (p_ovl) else $error("overload held");
   property p_tmr; ce && !timer_one_start |=> !timer_one_done; endproperty
   a_tmr: assert property (p_tmr) else $error("timer held");
endmodule // dsl_monitor

// ---- dsl_pkg.sv ----
// Drive supervision constants: register map, reset values, timing.
// Assumes a 20 MHz pclk and 32-bit APB data.
package dsl_pkg;
   localparam int CLK_HZ = 20_000_000;
   // Slow time base: one tick every 0.1 s.
   localparam int TICK_MS = 100;
   localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
   localparam int WINDOW_S = 60;
   localparam int WINDOW_TICKS = WINDOW_S * 1000 / TICK_MS;

   // Register byte offsets.
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_BRAKE = 12'h004;
   localparam logic [11:0] OFS_RESTART = 12'h008;
   localparam logic [11:0] OFS_OVERCUR = 12'h00C;
   localparam logic [11:0] OFS_FDET = 12'h010;
   localparam logic [11:0] OFS_FBAND = 12'h014;
   localparam logic [11:0] OFS_TIMERS = 12'h018;
   localparam logic [11:0] OFS_SKIP = 12'h01C;
   localparam logic [11:0] OFS_SKIPW = 12'h020;
   localparam logic [11:0] OFS_STATUS = 12'h024;
   localparam logic [11:0] OFS_FREQ_IN = 12'h028;

   // Reset values (volts x10, seconds x10, Hz x100, percent x100).
   localparam logic [15:0] BRAKE_ON_400V = 16'h1B58;
   localparam logic [15:0] BRAKE_ON_230V = 16'h0E74;
   localparam logic [15:0] BRAKE_HYST_RST = 16'h0064;
   localparam logic PL_RESTART_RST = 1'b1;
   localparam logic [1:0] PL_ACTION_RST = 2'h0;
   localparam logic [4:0] RESTART_LIMIT_RST = 5'h00;
   localparam logic [4:0] RESTART_LIMIT_MAX = 5'h14;
   localparam logic [15:0] RESTART_DELAY_RST = 16'h000A;
   localparam logic [15:0] RESTART_DELAY_MIN = 16'h0001;
   localparam logic [15:0] RESTART_DELAY_MAX = 16'h03E8;
   localparam logic [7:0] OC_LEVEL_RST = 8'h00;
   localparam logic [7:0] OC_LEVEL_MAX = 8'hC8;
   localparam logic [15:0] OC_TIME_RST = 16'h0064;
   localparam logic [15:0] FDET_BAND_RST = 16'h01F4;
   localparam logic [15:0] FDET_BAND_MAX = 16'h2710;
   localparam logic [15:0] TIMER1_RST = 16'h0064;
   localparam logic [15:0] TIMER2_RST = 16'h00C8;
   localparam logic [15:0] TIME_MAX = 16'h270F;

   typedef enum logic [1:0] {
      PLA_NONE = 2'b00,
      PLA_RAMP = 2'b01,
      PLA_RAMP_PLUS = 2'b10
   } dsl_pla_e;

   typedef enum logic [1:0] {
      RS_RUN = 2'b00,
      RS_DELAY = 2'b01,
      RS_LOCKED = 2'b10
   } dsl_rs_e;
endpackage

// ---- dsl_power_model.sv ----
// Power stage model: bus voltage and output frequency.
// Assumes regen from the bench fills the bus.
`timescale 1ns/1ps
module dsl_power_model
   import dsl_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Stimulus and chopper
   input wire logic regen,
   input wire logic brake_on,
   input wire logic [15:0] freq_setpoint,
   // Measurements
   output logic [15:0] dc_bus_dv,
   output logic [15:0] out_freq_chz
);
   // The chopper drains faster than regeneration fills.
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         dc_bus_dv <= 16'h1770;
      else
         dc_bus_dv <= dc_bus_dv + (regen ? 16'h0014 : 16'h0000)
            - (brake_on ? 16'h0028 : 16'h0000);
   always_ff @(posedge pclk)
      out_freq_chz <= freq_setpoint;
endmodule // dsl_power_model

// ---- dsl_supervisor.sv ----
// Drive supervision: brake, power loss, fault restart, overcurrent,
// frequency detect, timers and jump frequencies.
// Assumes an APB master on pclk and synchronous inputs.
//
// Functional notes
// - Chopper on above brake threshold.
// - Chopper off at release level.
// - Select 0: run dropped on supply loss.
// - Select 1: run kept, speed search on return.
// - Loss action: 0 none, 1 ramp, 2 ramp plus extra.
// - Fault, nonzero limit: restart after delay.
// - 60 s without alarm clears restart count.
// - Count at limit stops output.
// - Limit 0 to 20, default 0; zero disables.
// - Overcurrent level: percent of rated current.
// - Too long above level raises overload.
// - Level zero, the default, disables detection.
// - Two levels set reached flags.
// - Shared hysteresis, 0.01 %, default 5.0 %.
// - Timers flag at presets, 10.0 s and 20.0 s.
// - Two jump frequencies, 0.01 Hz, default 0.
// - Jump band width, 0.01 Hz, default 0.
// - Brake default 700.0 V or 370.0 V by model.
//
// Chosen here: register access over APB and the address map.
`timescale 1ns/1ps
module dsl_supervisor
   import dsl_pkg::*;
#(
   parameter int unsigned TICK_DIV = TICK_CYCLES
)
(
   // Clock, reset, enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Model strap: high on 230 V models
   input wire logic model_230v,
   // Power stage measurements
   input wire logic [15:0] dc_bus_dv,
   input wire logic [15:0] motor_current_ca,
   input wire logic [15:0] out_freq_chz,
   input wire logic [15:0] req_freq_chz,
   input wire logic supply_ok,
   input wire logic fault_alarm,
   input wire logic run_cmd,
   // Multifunction inputs
   input wire logic timer_one_start,
   input wire logic timer_two_start,
   // Outputs
   output logic brake_on,
   output logic run_enable,
   output logic speed_search,
   output logic pl_ramp_down,
   output logic pl_extra_action,
   output logic auto_restart,
   output logic output_inhibit,
   output logic motor_overload_alarm,
   output logic freq_reached_flag_one,
   output logic freq_reached_flag_two,
   output logic timer_one_done,
   output logic timer_two_done,
   output logic [15:0] freq_setpoint
);
   initial
   begin
      if (TICK_DIV < 2)
         $error("TICK_DIV too small");
   end

   dsl_tick_if tk ();

   // Configuration registers.
   logic [15:0] brake_on_threshold_reg, brake_hyst_reg;
   logic power_loss_restart_select_reg;
   logic [1:0] power_loss_action_select_reg;
   logic [4:0] fault_restart_limit_reg;
   logic [15:0] fault_restart_delay_reg;
   logic [7:0] motor_overcurrent_level_reg;
   logic [15:0] rated_motor_current_reg, motor_overcurrent_time_reg;
   logic [15:0] freq_detect_level_one_reg, freq_detect_level_two_reg;
   logic [15:0] freq_detect_band_reg;
   logic [15:0] gp_timer_one_preset_reg, gp_timer_two_preset_reg;
   logic [15:0] skip_freq_one_reg, skip_freq_two_reg, skip_band_width_reg;
   logic strap_done_reg;

   // Supervision state.
   logic [31:0] div_reg, div_next;
   logic tick_reg, tick_next;
   logic brake_reg, brake_next;
   logic run_held_reg, run_held_next;
   logic search_reg, search_next;
   logic supply_q_reg;
   dsl_rs_e rs_reg, rs_next;
   logic [15:0] rs_cnt_reg, rs_cnt_next;
   logic [4:0] fault_cnt_reg, fault_cnt_next;
   logic fault_q_reg;
   logic restart_pulse_reg, restart_pulse_next;
   logic [15:0] oc_cnt_reg, oc_cnt_next;
   logic ol_reg, ol_next;
   logic [15:0] setp_reg, setp_next;
   logic [31:0] prdata_reg;

   logic wr_en, rd_en;
   logic [16:0] release_lvl;
   logic [31:0] oc_limit;
   logic fault_rise;

   assign tk.ce = ce;
   assign tk.tick = tick_reg;
   assign wr_en = psel && penable && pwrite && ce;
   assign rd_en = psel && !penable && !pwrite;
   assign fault_rise = fault_alarm && !fault_q_reg;
   assign release_lvl = 17'(brake_on_threshold_reg) - 17'(brake_hyst_reg);
   // Current limit in 0.01 A: rated x percent / 100.
   assign oc_limit = (32'(rated_motor_current_reg)
      * 32'(motor_overcurrent_level_reg)) / 32'd100;

   always_comb
   begin
      div_next = div_reg + 32'd1;
      tick_next = 1'b0;
      if (div_reg >= 32'(TICK_DIV - 1))
      begin
         div_next = 32'd0;
         tick_next = 1'b1;
      end

      brake_next = brake_reg;
      if (dc_bus_dv > brake_on_threshold_reg)
         brake_next = 1'b1;
      else if (release_lvl[16] || 17'(dc_bus_dv) <= release_lvl)
         brake_next = 1'b0;

      run_held_next = run_held_reg;
      search_next = 1'b0;
      if (supply_ok)
      begin
         run_held_next = run_cmd;
         search_next = !supply_q_reg && run_held_reg;
      end
      else if (!power_loss_restart_select_reg)
         run_held_next = 1'b0;

      rs_next = rs_reg;
      rs_cnt_next = rs_cnt_reg;
      fault_cnt_next = fault_cnt_reg;
      restart_pulse_next = 1'b0;
      case (rs_reg)
         RS_RUN:
         begin
            if (fault_rise)
            begin
               rs_cnt_next = 16'h0000;
               if (fault_restart_limit_reg == 5'h00)
                  rs_next = RS_LOCKED;
               else if (fault_cnt_reg + 5'h01 >= fault_restart_limit_reg)
               begin
                  fault_cnt_next = fault_cnt_reg + 5'h01;
                  rs_next = RS_LOCKED;
               end
               else
               begin
                  fault_cnt_next = fault_cnt_reg + 5'h01;
                  rs_next = RS_DELAY;
               end
            end
            else if (tick_reg && fault_cnt_reg != 5'h00)
            begin
               rs_cnt_next = rs_cnt_reg + 16'h0001;
               if (rs_cnt_reg + 16'h0001 >= 16'(WINDOW_TICKS))
               begin
                  fault_cnt_next = 5'h00;
                  rs_cnt_next = 16'h0000;
               end
            end
         end
         RS_DELAY:
         begin
            if (tick_reg)
               rs_cnt_next = rs_cnt_reg + 16'h0001;
            if (rs_cnt_reg >= fault_restart_delay_reg && !fault_alarm)
            begin
               rs_next = RS_RUN;
               rs_cnt_next = 16'h0000;
               restart_pulse_next = 1'b1;
            end
         end
         RS_LOCKED:
         begin
            if (!run_cmd && !fault_alarm)
            begin
               rs_next = RS_RUN;
               fault_cnt_next = 5'h00;
            end
         end
         default: rs_next = RS_RUN;
      endcase

      oc_cnt_next = oc_cnt_reg;
      ol_next = ol_reg;
      if (motor_overcurrent_level_reg == 8'h00)
      begin
         oc_cnt_next = 16'h0000;
         ol_next = 1'b0;
      end
      else if (32'(motor_current_ca) > oc_limit)
      begin
         if (tick_reg && oc_cnt_reg != 16'hFFFF)
            oc_cnt_next = oc_cnt_reg + 16'h0001;
         if (oc_cnt_reg > motor_overcurrent_time_reg)
            ol_next = 1'b1;
      end
      else
         oc_cnt_next = 16'h0000;
      if (!run_cmd)
         ol_next = 1'b0;

      setp_next = req_freq_chz;
      if (skip_band_width_reg != 16'h0000)
      begin
         if (skip_freq_one_reg != 16'h0000
            && jump_hold(req_freq_chz, skip_freq_one_reg,
                         skip_band_width_reg, setp_reg))
            setp_next = setp_reg;
         else if (skip_freq_two_reg != 16'h0000
            && jump_hold(req_freq_chz, skip_freq_two_reg,
                         skip_band_width_reg, setp_reg))
            setp_next = setp_reg;
      end
   end

   // Holds while the request sits in the band; held is the last setpoint from outside it.
   function automatic logic jump_hold(input logic [15:0] req,
      input logic [15:0] ctr, input logic [15:0] bw,
      input logic [15:0] held);
      logic [16:0] lo;
      logic [16:0] hi;
      lo = 17'(ctr) - 17'(bw >> 1);
      hi = 17'(ctr) + 17'(bw >> 1);
      if (lo[16])
         lo = 17'h0_0000;
      jump_hold = (17'(req) > lo) && (17'(req) < hi)
         && (17'(held) <= lo || 17'(held) >= hi);
   endfunction

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         div_reg <= 32'd0;
         tick_reg <= 1'b0;
         brake_reg <= 1'b0;
         run_held_reg <= 1'b0;
         search_reg <= 1'b0;
         supply_q_reg <= 1'b0;
         rs_reg <= RS_RUN;
         rs_cnt_reg <= 16'h0000;
         fault_cnt_reg <= 5'h00;
         fault_q_reg <= 1'b0;
         restart_pulse_reg <= 1'b0;
         oc_cnt_reg <= 16'h0000;
         ol_reg <= 1'b0;
         setp_reg <= 16'h0000;
      end
      else if (ce)
      begin
         div_reg <= div_next;
         tick_reg <= tick_next;
         brake_reg <= brake_next;
         run_held_reg <= run_held_next;
         search_reg <= search_next;
         supply_q_reg <= supply_ok;
         rs_reg <= rs_next;
         rs_cnt_reg <= rs_cnt_next;
         fault_cnt_reg <= fault_cnt_next;
         fault_q_reg <= fault_alarm;
         restart_pulse_reg <= restart_pulse_next;
         oc_cnt_reg <= oc_cnt_next;
         ol_reg <= ol_next;
         setp_reg <= setp_next;
      end
   end

   // Register file; the model strap is taken once after reset.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         brake_on_threshold_reg <= BRAKE_ON_400V;
         brake_hyst_reg <= BRAKE_HYST_RST;
         strap_done_reg <= 1'b0;
         power_loss_restart_select_reg <= PL_RESTART_RST;
         power_loss_action_select_reg <= PL_ACTION_RST;
         fault_restart_limit_reg <= RESTART_LIMIT_RST;
         fault_restart_delay_reg <= RESTART_DELAY_RST;
         motor_overcurrent_level_reg <= OC_LEVEL_RST;
         rated_motor_current_reg <= 16'h0000;
         motor_overcurrent_time_reg <= OC_TIME_RST;
         freq_detect_level_one_reg <= 16'h0000;
         freq_detect_level_two_reg <= 16'h0000;
         freq_detect_band_reg <= FDET_BAND_RST;
         gp_timer_one_preset_reg <= TIMER1_RST;
         gp_timer_two_preset_reg <= TIMER2_RST;
         skip_freq_one_reg <= 16'h0000;
         skip_freq_two_reg <= 16'h0000;
         skip_band_width_reg <= 16'h0000;
      end
      else if (ce)
      begin
         if (!strap_done_reg)
         begin
            strap_done_reg <= 1'b1;
            if (model_230v)
               brake_on_threshold_reg <= BRAKE_ON_230V;
         end
         else if (wr_en)
         begin
            if (paddr == OFS_CTRL)
            begin
               power_loss_restart_select_reg <= pwdata[0];
               if (pwdata[5:4] <= 2'h2)
                  power_loss_action_select_reg <= pwdata[5:4];
            end
            else if (paddr == OFS_BRAKE)
            begin
               brake_on_threshold_reg <= pwdata[15:0];
               brake_hyst_reg <= pwdata[31:16];
            end
            else if (paddr == OFS_RESTART)
            begin
               if (pwdata[4:0] <= RESTART_LIMIT_MAX)
                  fault_restart_limit_reg <= pwdata[4:0];
               if (pwdata[31:16] >= RESTART_DELAY_MIN
                  && pwdata[31:16] <= RESTART_DELAY_MAX)
                  fault_restart_delay_reg <= pwdata[31:16];
            end
            else if (paddr == OFS_OVERCUR)
            begin
               if (pwdata[7:0] <= OC_LEVEL_MAX)
                  motor_overcurrent_level_reg <= pwdata[7:0];
               if (pwdata[31:16] <= TIME_MAX)
                  motor_overcurrent_time_reg <= pwdata[31:16];
            end
            else if (paddr == OFS_FDET)
            begin
               freq_detect_level_one_reg <= pwdata[15:0];
               freq_detect_level_two_reg <= pwdata[31:16];
            end
            else if (paddr == OFS_FBAND)
            begin
               if (pwdata[15:0] <= FDET_BAND_MAX)
                  freq_detect_band_reg <= pwdata[15:0];
               rated_motor_current_reg <= pwdata[31:16];
            end
            else if (paddr == OFS_TIMERS)
            begin
               if (pwdata[15:0] <= TIME_MAX)
                  gp_timer_one_preset_reg <= pwdata[15:0];
               if (pwdata[31:16] <= TIME_MAX)
                  gp_timer_two_preset_reg <= pwdata[31:16];
            end
            else if (paddr == OFS_SKIP)
            begin
               skip_freq_one_reg <= pwdata[15:0];
               skip_freq_two_reg <= pwdata[31:16];
            end
            else if (paddr == OFS_SKIPW)
               skip_band_width_reg <= pwdata[15:0];
         end
      end
   end

   // Read data is taken in setup and shown in access.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata_reg <= 32'h0000_0000;
      else if (ce && rd_en)
      begin
         if (paddr == OFS_CTRL)
            prdata_reg <= {26'h0, power_loss_action_select_reg, 3'h0,
               power_loss_restart_select_reg};
         else if (paddr == OFS_BRAKE)
            prdata_reg <= {brake_hyst_reg, brake_on_threshold_reg};
         else if (paddr == OFS_RESTART)
            prdata_reg <= {fault_restart_delay_reg, 3'h0, fault_cnt_reg,
               3'h0, fault_restart_limit_reg};
         else if (paddr == OFS_OVERCUR)
            prdata_reg <= {motor_overcurrent_time_reg, 8'h00,
               motor_overcurrent_level_reg};
         else if (paddr == OFS_FDET)
            prdata_reg <= {freq_detect_level_two_reg,
               freq_detect_level_one_reg};
         else if (paddr == OFS_FBAND)
            prdata_reg <= {rated_motor_current_reg, freq_detect_band_reg};
         else if (paddr == OFS_TIMERS)
            prdata_reg <= {gp_timer_two_preset_reg, gp_timer_one_preset_reg};
         else if (paddr == OFS_SKIP)
            prdata_reg <= {skip_freq_two_reg, skip_freq_one_reg};
         else if (paddr == OFS_SKIPW)
            prdata_reg <= {16'h0000, skip_band_width_reg};
         else if (paddr == OFS_STATUS)
            prdata_reg <= {20'h0_0000, timer_two_done, timer_one_done,
               freq_reached_flag_two, freq_reached_flag_one, ol_reg,
               rs_reg == RS_LOCKED, rs_reg == RS_DELAY, search_reg,
               run_held_reg, brake_reg, 2'h0};
         else if (paddr == OFS_FREQ_IN)
            prdata_reg <= {out_freq_chz, setp_reg};
         else
            prdata_reg <= 32'h0000_0000;
      end
   end

   assign prdata = prdata_reg;
   assign pready = ce;
   assign pslverr = psel && penable && (paddr > OFS_FREQ_IN
      || paddr[1:0] != 2'h0);

   dsl_freq_detect u_fd1 (.pclk(pclk), .presetn(presetn), .tk(tk),
      .freq(out_freq_chz), .level(freq_detect_level_one_reg),
      .band(freq_detect_band_reg), .reached(freq_reached_flag_one));
   dsl_freq_detect u_fd2 (.pclk(pclk), .presetn(presetn), .tk(tk),
      .freq(out_freq_chz), .level(freq_detect_level_two_reg),
      .band(freq_detect_band_reg), .reached(freq_reached_flag_two));
   dsl_gp_timer u_t1 (.pclk(pclk), .presetn(presetn), .tk(tk),
      .start(timer_one_start), .preset(gp_timer_one_preset_reg),
      .done(timer_one_done));
   dsl_gp_timer u_t2 (.pclk(pclk), .presetn(presetn), .tk(tk),
      .start(timer_two_start), .preset(gp_timer_two_preset_reg),
      .done(timer_two_done));

   assign brake_on = brake_reg;
   assign run_enable = run_held_reg && supply_ok && rs_reg == RS_RUN
      && !ol_reg;
   assign speed_search = search_reg;
   assign pl_ramp_down = !supply_ok
      && power_loss_action_select_reg != PLA_NONE;
   assign pl_extra_action = !supply_ok
      && power_loss_action_select_reg == PLA_RAMP_PLUS;
   assign auto_restart = restart_pulse_reg;
   assign output_inhibit = rs_reg != RS_RUN || ol_reg;
   assign motor_overload_alarm = ol_reg;
   assign freq_setpoint = setp_reg;
endmodule // dsl_supervisor

// ---- dsl_tick_if.sv ----
// Shared 0.1 s tick and clock enable for the timers and frequency detectors.
// Assumes one clock domain.
`timescale 1ns/1ps
interface dsl_tick_if;
   logic ce;
   logic tick;
   modport src (output ce, output tick);
   modport dst (input ce, input tick);
endinterface

// ---- tb_top.sv ----
// Bench for the drive supervisor and power model.
// Assumes TICK_DIV 10: a 0.1 s tick is 10 pclk cycles.
`timescale 1ns/1ps
module tb_top
   import dsl_pkg::*;
;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic pready, pslverr, model_230v = 0, supply_ok = 1, fault_alarm = 0;
   logic run_cmd = 1, tstart = 0, regen = 0, brake_on, speed_search, found;
   logic pl_ramp_down, pl_extra_action, auto_restart, timer_one_done;
   logic motor_overload_alarm, freq_reached_flag_one;
   logic [15:0] motor_current_ca = '0, req_freq_chz = '0, freq_setpoint;
   logic [15:0] dc_bus_dv, out_freq_chz;
   int miscompares = 0, samples_checked = 0, n;
   dsl_supervisor #(.TICK_DIV(10)) u_dut (.*, .ce(1'b1),
      .timer_one_start(tstart), .timer_two_start(tstart), .run_enable(),
      .output_inhibit(), .freq_reached_flag_two(), .timer_two_done());
   dsl_power_model u_model (.*);
   initial forever #25 pclk = ~pclk;
   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a,
         input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_for(ref logic s, input logic v);
      for (int i = 0; i < 200 && s !== v; i++)
         @(posedge pclk);
      check(s, v);
   endtask
   task automatic alarm;
      fault_alarm <= 1'b1;
      repeat (2) @(posedge pclk);
      fault_alarm <= 1'b0;
      for (n = 0; n < 40 && auto_restart !== 1'b1; n++)
         @(posedge pclk);
   endtask
   task automatic t_regs;
      logic [11:0] a [8] = '{OFS_CTRL, OFS_BRAKE, OFS_RESTART, OFS_OVERCUR,
         OFS_TIMERS, OFS_SKIP, OFS_SKIPW, 12'h030};
      logic [31:0] e [8] = '{32'h0000_0001, 32'h0064_1B58, 32'h000A_0000,
         32'h0064_0000, 32'h00C8_0064, '0, '0, '0};
      foreach (a[i])
      begin
         apb(1'b0, a[i], '0);
         check({err, rd}, {a[i] == 12'h030, e[i]});
      end
      apb(1'b0, OFS_FBAND, '0);
      check(rd[15:0], FDET_BAND_RST);
      apb(1'b1, OFS_CTRL, 32'h0000_0031);
      apb(1'b0, OFS_CTRL, '0);
      check(rd, 32'h0000_0001);
   endtask
   task automatic t_brake;
      regen <= 1'b1;
      wait_for(brake_on, 1'b1);
      wait_for(brake_on, 1'b0);
      regen <= 1'b0;
   endtask
   task automatic t_power;
      for (int m = 0; m < 4; m++)
      begin
         apb(1'b1, OFS_CTRL, m == 3 ? '0 : 32'({m[1:0], 4'h1}));
         supply_ok <= 1'b0;
         repeat (3) @(posedge pclk);
         check({pl_ramp_down, pl_extra_action}, {m == 1 || m == 2, m == 2});
         supply_ok <= 1'b1;
         found = 0;
         repeat (4)
         begin
            @(posedge pclk);
            found |= speed_search;
         end
         check(found, m != 3);
      end
      run_cmd <= 1'b0;
      @(posedge pclk);
      run_cmd <= 1'b1;
   endtask
   task automatic t_fault;
      alarm;
      apb(1'b0, OFS_STATUS, '0);
      check({n, rd[6]}, {32'd40, 1'b1});
      run_cmd <= 1'b0;
      apb(1'b1, OFS_RESTART, 32'h0001_0002);
      run_cmd <= 1'b1;
      alarm;
      check(n > 0 && n < 25, 1'b1);
      repeat (6200) @(posedge pclk);
      apb(1'b0, OFS_RESTART, '0);
      check(rd[12:8], 5'h00);
      alarm;
      alarm;
      apb(1'b0, OFS_STATUS, '0);
      check({n, rd[6]}, {32'd40, 1'b1});
   endtask
   task automatic t_ovl;
      apb(1'b1, OFS_FBAND, 32'h0100_01F4);
      apb(1'b1, OFS_OVERCUR, 32'h0002_0064);
      motor_current_ca <= 16'h0105;
      repeat (15) @(posedge pclk);
      check(motor_overload_alarm, 1'b0);
      repeat (30) @(posedge pclk);
      check(motor_overload_alarm, 1'b1);
      motor_current_ca <= '0;
      run_cmd <= 1'b0;
   endtask
   task automatic t_freq;
      logic [15:0] q [5] = '{16'd1500, 16'd2050, 16'd2150, 16'd960, 16'd940};
      logic [15:0] s [5] = '{16'd1500, 16'd1500, 16'd2150, 16'd960, 16'd940};
      apb(1'b1, OFS_FDET, 32'h0000_03E8);
      apb(1'b1, OFS_SKIP, 32'h0000_07D0);
      apb(1'b1, OFS_SKIPW, 32'h0000_00C8);
      foreach (q[i])
      begin
         req_freq_chz <= q[i];
         repeat (25) @(posedge pclk);
         check({freq_setpoint, freq_reached_flag_one}, {s[i], i < 4});
      end
   endtask
   task automatic t_timer;
      tstart <= 1'b1;
      repeat (900) @(posedge pclk);
      check(timer_one_done, 1'b0);
      repeat (200) @(posedge pclk);
      check(timer_one_done, 1'b1);
      tstart <= 1'b0;
   endtask
   task automatic conclude;
      $display("checks=%0d mismatches=%0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial
   begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_brake;
      t_power;
      t_fault;
      t_ovl;
      t_freq;
      t_timer;
      presetn <= 1'b0;
      model_230v <= 1'b1;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      wait_for(brake_on, 1'b1);
      conclude;
   end
   initial
   begin
      #1_000_000;
      miscompares++;
      conclude;
   end
endmodule // tb_top
bind dsl_supervisor dsl_monitor u_mon (.*);
